// ===== cfr_freq_regs.sv
// Top: CPU frequency program registers, recovery selection and output mux
`default_nettype none
// Contract
// - While recovery is active, writing recovery N or recovery M retunes the output at once.
// - Recovery source flag: 0 uses latched strap code, 1 uses recovery N/M.
// - Watchdog time-out switches to the recovery frequency without host help.
// - With source flag set, recovery frequency comes from recovery N and M.
// - Programmable mode derives output from programmable N and M.
// - Programmable M write loads new frequency; N-only write does not.
// - Strap-override clear uses latched strap code, set uses software select code.
module cfr_freq_regs
  import cfr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // Bus pins (asynchronous)
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_n_o,
  // Straps and control (asynchronous pins)
  input  wire logic [4:0] strap_pins_i,
  input  wire logic       strap_override_flag_i,
  input  wire logic [4:0] soft_select_code_i,
  // Watchdog time-out pulse, same clock
  input  wire logic       wdt_timeout_i,
  // Frequency outputs
  output var  logic       use_nm_o,
  output var  logic [7:0] synth_n_o,
  output var  logic [6:0] synth_m_o,
  output var  logic [4:0] ratio_code_o,
  output var  logic       retune_o,
  output var  logic       recovery_active_o
);
  // ==========================================================================
  // Pin synchronisers
  logic       scl_m_q, scl_s_q, sda_m_q, sda_s_q, ovr_m_q, ovr_s_q;
  logic [4:0] strap_m_q, strap_s_q, sel_m_q, sel_s_q;

  // Two flops per asynchronous input before any logic
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hF;
      {ovr_m_q, ovr_s_q}                   <= 2'h0;
      {sel_m_q, sel_s_q}                   <= 10'h000;
    end
    else
    begin
      scl_m_q   <= scl_i;
      scl_s_q   <= scl_m_q;
      sda_m_q   <= sda_i;
      sda_s_q   <= sda_m_q;
      ovr_m_q   <= strap_override_flag_i;
      ovr_s_q   <= ovr_m_q;
      sel_m_q   <= soft_select_code_i;
      sel_s_q   <= sel_m_q;
    end
  end

  // Strap synchroniser runs through reset, so it already holds the pins
  // when the one-shot capture fires on the first edge after release
  always_ff @(posedge sys_clk_i)
  begin
    strap_m_q <= strap_pins_i;
    strap_s_q <= strap_m_q;
  end

  // ==========================================================================
  // Bus slave
  cfr_wr_t    wr;
  logic [7:0] rd_addr, rd_data;

  cfr_smb_slave u_slave (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .scl_s_i    (scl_s_q),
    .sda_s_i    (sda_s_q),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o),
    .wr_o       (wr),
    .rd_addr_o  (rd_addr),
    .rd_data_i  (rd_data)
  );

  // ==========================================================================
  // Register file
  logic [7:0] rec_n_q, rec_n_d, rec_m_q, rec_m_d;
  logic [7:0] prog_n_q, prog_n_d, prog_m_q, prog_m_d;
  logic [4:0] strap_q, strap_d;
  logic       strap_done_q, strap_done_d;

  function automatic logic hit(input cfr_wr_t w, input logic [7:0] ofs);
    hit = w.valid && (w.addr == ofs);
  endfunction

  // Byte writes; straps caught once after reset release
  always_comb
  begin
    rec_n_d      = hit(wr, CFR_OFS_REC_N)  ? wr.data : rec_n_q;
    rec_m_d      = hit(wr, CFR_OFS_REC_M)  ? wr.data : rec_m_q;
    prog_n_d     = hit(wr, CFR_OFS_PROG_N) ? wr.data : prog_n_q;
    prog_m_d     = hit(wr, CFR_OFS_PROG_M) ? wr.data : prog_m_q;
    strap_d      = strap_done_q ? strap_q : strap_s_q;
    strap_done_d = 1'b1;
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    case (rd_addr)
      CFR_OFS_REC_N:  rd_data = rec_n_q;
      CFR_OFS_REC_M:  rd_data = rec_m_q;
      CFR_OFS_PROG_N: rd_data = prog_n_q;
      CFR_OFS_PROG_M: rd_data = prog_m_q;
      default:        rd_data = CFR_RD_UNMAP;
    endcase
  end

  // Strap capture fires on the first edge after reset release; the synchroniser is already full
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rec_n_q      <= CFR_RST_BYTE;
      rec_m_q      <= CFR_RST_BYTE;
      prog_n_q     <= CFR_RST_BYTE;
      prog_m_q     <= CFR_RST_BYTE;
      strap_q      <= '0;
      strap_done_q <= 1'b0;
    end
    else
    begin
      rec_n_q      <= rec_n_d;
      rec_m_q      <= rec_m_d;
      prog_n_q     <= prog_n_d;
      prog_m_q     <= prog_m_d;
      strap_q      <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ==========================================================================
  // Frequency selection
  cfr_freq_t  fr_q, fr_d;
  logic       rec_q, rec_d, retune_d;
  logic       src_nm, prog_en, rec_wr, prog_ld;

  assign src_nm  = rec_m_d[CFR_SRC_BIT];
  assign prog_en = prog_m_d[CFR_PEN_BIT];
  assign rec_wr  = hit(wr, CFR_OFS_REC_N) | hit(wr, CFR_OFS_REC_M);
  assign prog_ld = hit(wr, CFR_OFS_PROG_M);

  // Recovery wins over programmable mode; sticky until reset because the
  // watchdog normally also resets the system
  always_comb
  begin
    rec_d    = rec_q | wdt_timeout_i;
    retune_d = 1'b0;
    fr_d     = fr_q;
    if (rec_d)
    begin
      if (wdt_timeout_i || rec_wr)
      begin
        retune_d = 1'b1;
        if (src_nm)
          fr_d = '{use_nm: 1'b1, n: rec_n_d, m: rec_m_d[6:0], ratio: fr_q.ratio};
        else
          fr_d = '{use_nm: 1'b0, n: fr_q.n, m: fr_q.m, ratio: strap_q};
      end
    end
    else if (prog_en)
    begin
      if (prog_ld)
      begin
        retune_d = 1'b1;
        fr_d = '{use_nm: 1'b1, n: prog_n_d, m: prog_m_d[6:0], ratio: fr_q.ratio};
      end
    end
    else
    begin
      retune_d = fr_q.use_nm;
      fr_d.use_nm = 1'b0;
      fr_d.ratio  = ovr_s_q ? sel_s_q : strap_q;
    end
  end

  // N and M leave raw; the synthesizer owns the N/M-to-frequency relation
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rec_q <= 1'b0;
      fr_q  <= '0;
      retune_o <= 1'b0;
    end
    else
    begin
      rec_q <= rec_d;
      fr_q  <= fr_d;
      retune_o <= retune_d;
    end
  end

  assign use_nm_o          = fr_q.use_nm;
  assign synth_n_o         = fr_q.n;
  assign synth_m_o         = fr_q.m;
  assign ratio_code_o      = fr_q.ratio;
  assign recovery_active_o = rec_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  chk_rec_write_retune: assert property (
    (hit(wr, CFR_OFS_REC_N) && rec_q && rec_m_q[CFR_SRC_BIT])
    |=> retune_o && synth_n_o == $past(wr.data))
    else $error("recovery N write did not retune");
  chk_src_strap: assert property (
    (wdt_timeout_i && !rec_q && !rec_m_d[CFR_SRC_BIT])
    |=> !use_nm_o && ratio_code_o == $past(strap_q))
    else $error("strap recovery source not applied");
  chk_wdt_switch: assert property (
    wdt_timeout_i |=> recovery_active_o && retune_o)
    else $error("time-out did not switch to recovery");
  chk_rec_nm_apply: assert property (
    (wdt_timeout_i && !wr.valid && rec_m_q[CFR_SRC_BIT])
    |=> use_nm_o && synth_n_o == $past(rec_n_q) && synth_m_o == $past(rec_m_q[6:0]))
    else $error("recovery N/M not applied");
  chk_prog_load: assert property (
    (prog_ld && wr.data[CFR_PEN_BIT] && !rec_q && !wdt_timeout_i)
    |=> use_nm_o && synth_n_o == $past(prog_n_q) && synth_m_o == $past(wr.data[6:0]))
    else $error("programmable N/M not applied");
  chk_prog_n_only: assert property (
    (hit(wr, CFR_OFS_PROG_N) && prog_m_q[CFR_PEN_BIT] && use_nm_o && !rec_q && !wdt_timeout_i)
    |=> !retune_o && $stable(synth_n_o))
    else $error("N-only write changed frequency");
  chk_ratio_select: assert property (
    (!rec_q && !wdt_timeout_i && !prog_m_d[CFR_PEN_BIT])
    |=> ratio_code_o == ($past(ovr_s_q) ? $past(sel_s_q) : $past(strap_q)))
    else $error("ratio source wrong");
  chk_reg_reset: assert property (
    $past(reset_i) |-> rec_n_q == CFR_RST_BYTE && rec_m_q == CFR_RST_BYTE
                       && prog_n_q == CFR_RST_BYTE && !recovery_active_o)
    else $error("registers not zero after reset");

  cov_rec_nm: cover property (wdt_timeout_i && rec_m_q[CFR_SRC_BIT]);
  cov_rec_strap: cover property (wdt_timeout_i && !rec_m_q[CFR_SRC_BIT]);
  cov_prog_load: cover property (prog_ld && prog_en && !rec_q);
  cov_override: cover property (ovr_s_q && !rec_q && !prog_en);
endmodule
`default_nettype wire

// ===== cfr_pkg.sv
// Constants, types and register map for the CPU frequency program registers
`default_nettype none
package cfr_pkg;
  // ==========================================================================
  // Register map (byte offsets on the serial management bus)
  localparam logic [7:0] CFR_OFS_REC_N  = 8'h0B;
  localparam logic [7:0] CFR_OFS_REC_M  = 8'h0C;
  localparam logic [7:0] CFR_OFS_PROG_N = 8'h0D;
  localparam logic [7:0] CFR_OFS_PROG_M = 8'h0E;
  localparam logic [7:0] CFR_RST_BYTE   = 8'h00;
  localparam logic [7:0] CFR_RD_UNMAP   = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int unsigned CFR_SRC_BIT   = 7;   // Recovery source flag in recovery M
  localparam int unsigned CFR_PEN_BIT   = 7;   // Programmable enable in programmable M
  // ==========================================================================
  // Serial slave constants
  localparam logic [6:0] CFR_SLV_ADDR   = 7'h2A;  // Arbitrary default slave address
  localparam logic [3:0] CFR_BITS_BYTE  = 4'h8;
  localparam logic [3:0] CFR_LAST_TXBIT = 4'h7;
  localparam logic [3:0] CFR_CNT_ONE    = 4'h1;
  localparam logic [7:0] CFR_PTR_ONE    = 8'h01;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } cfr_wr_t;

  typedef struct packed {
    logic       use_nm;
    logic [7:0] n;
    logic [6:0] m;
    logic [4:0] ratio;
  } cfr_freq_t;

  typedef enum logic [2:0] {
    CFR_S_IDLE = 3'h0,
    CFR_S_ADDR = 3'h1,
    CFR_S_RX   = 3'h2,
    CFR_S_ACK  = 3'h3,
    CFR_S_TX   = 3'h7,
    CFR_S_MACK = 3'h6
  } cfr_slv_state_t;
endpackage
`default_nettype wire

// ===== cfr_smb_slave.sv
// Serial management bus slave: byte pointer, auto-increment writes and reads
`default_nettype none
module cfr_smb_slave
  import cfr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // Bus pins, already synchronised
  input  wire logic       scl_s_i,
  input  wire logic       sda_s_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_n_o,
  // Register side
  output var  cfr_wr_t    wr_o,
  output var  logic [7:0] rd_addr_o,
  input  wire logic [7:0] rd_data_i
);
  cfr_slv_state_t st_q, st_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic       drv_q, drv_d, rw_q, rw_d, first_q, first_d;
  logic       scl_p_q, sda_p_q;
  cfr_wr_t    wr_d;
  logic       scl_rise, scl_fall, start_c, stop_c;

  // ==========================================================================
  // Edge and condition detection on the synchronised pins
  assign scl_rise = scl_s_i & ~scl_p_q;
  assign scl_fall = ~scl_s_i & scl_p_q;
  assign start_c  = scl_s_i & scl_p_q & sda_p_q & ~sda_s_i;
  assign stop_c   = scl_s_i & scl_p_q & ~sda_p_q & sda_s_i;

  // Next-state logic; start and stop override any bit in flight
  always_comb
  begin
    st_d    = st_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    cnt_d   = cnt_q;
    drv_d   = drv_q;
    rw_d    = rw_q;
    first_d = first_q;
    wr_d    = '0;
    if (start_c)
    begin
      st_d    = CFR_S_ADDR;
      cnt_d   = '0;
      drv_d   = 1'b0;
      first_d = 1'b1;
    end
    else if (stop_c)
    begin
      st_d  = CFR_S_IDLE;
      drv_d = 1'b0;
    end
    else
    begin
      case (st_q)
        CFR_S_ADDR, CFR_S_RX:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda_s_i};
            cnt_d   = cnt_q + CFR_CNT_ONE;
          end
          else if (scl_fall && cnt_q == CFR_BITS_BYTE)
          begin
            drv_d = 1'b1;
            st_d  = CFR_S_ACK;
            if (st_q == CFR_S_ADDR)
            begin
              rw_d = shift_q[0];
              if (shift_q[7:1] != CFR_SLV_ADDR)
              begin
                drv_d = 1'b0;  // Not ours: stay off the bus
                st_d  = CFR_S_IDLE;
              end
            end
            else if (first_q)
            begin
              ptr_d   = shift_q;  // First byte is the command/offset
              first_d = 1'b0;
            end
            else
            begin
              wr_d  = '{valid: 1'b1, addr: ptr_q, data: shift_q};
              ptr_d = ptr_q + CFR_PTR_ONE;
            end
          end
        end
        CFR_S_ACK:
        begin
          if (scl_fall)
          begin
            cnt_d = '0;
            if (rw_q)
            begin
              shift_d = rd_data_i;
              drv_d   = ~rd_data_i[7];
              st_d    = CFR_S_TX;
            end
            else
            begin
              drv_d = 1'b0;
              st_d  = CFR_S_RX;
            end
          end
        end
        CFR_S_TX:
        begin
          if (scl_fall)
          begin
            cnt_d = cnt_q + CFR_CNT_ONE;
            if (cnt_q == CFR_LAST_TXBIT)
            begin
              drv_d = 1'b0;
              ptr_d = ptr_q + CFR_PTR_ONE;
              st_d  = CFR_S_MACK;
            end
            else
            begin
              shift_d = {shift_q[6:0], 1'b0};
              drv_d   = ~shift_q[6];
            end
          end
        end
        CFR_S_MACK:
        begin
          if (scl_rise && sda_s_i)
            st_d = CFR_S_IDLE;  // Master NACK ends the read
          else if (scl_fall)
          begin
            cnt_d   = '0;
            shift_d = rd_data_i;
            drv_d   = ~rd_data_i[7];
            st_d    = CFR_S_TX;
          end
        end
        default:
        begin
          st_d  = CFR_S_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      st_q       <= CFR_S_IDLE;
      shift_q    <= '0;
      ptr_q      <= '0;
      cnt_q      <= '0;
      drv_q      <= 1'b0;
      rw_q       <= 1'b0;
      first_q    <= 1'b0;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      wr_o       <= '0;
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end
    else
    begin
      st_q       <= st_d;
      shift_q    <= shift_d;
      ptr_q      <= ptr_d;
      cnt_q      <= cnt_d;
      drv_q      <= drv_d;
      rw_q       <= rw_d;
      first_q    <= first_d;
      scl_p_q    <= scl_s_i;
      sda_p_q    <= sda_s_i;
      wr_o       <= wr_d;
      sda_o      <= 1'b0;  // Open drain: only ever pulls low
      sda_oe_n_o <= ~drv_d;
    end
  end

  assign rd_addr_o = ptr_q;
endmodule
`default_nettype wire

// ===== cfr_smb_host.sv
// Serial management bus host model: bit-banged writes and reads
`default_nettype none
module cfr_smb_host
  import cfr_pkg::*;
(
  // Bus pins, data is open drain
  output var  logic scl_o,
  output var  logic sda_pull_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 80;  // 160 ns link clock
  logic [7:0] rd_data;
  int         nacks;
  event       rd_ev;
  // Clock stands high and data is released between frames
  initial
  begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
    nacks      = 0;
  end
  // ==========================================================================
  // Bit level: data moves only mid-way through SCL low
  task automatic put_bit(input logic b);
    #(HALF/2) sda_pull_o = ~b;
    #(HALF/2) scl_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
  // Sample late in the high phase, once the slave has settled its bit
  task automatic get_bit(output logic b);
    #(HALF/2) sda_pull_o = 1'b0;
    #(HALF/2) scl_o = 1'b1;
    #(HALF-10) b = sda_i;
    #10 scl_o = 1'b0;
  endtask
  task automatic start_cond();
    #(HALF/2) sda_pull_o = 1'b0;
    #(HALF/2) scl_o = 1'b1;
    #HALF sda_pull_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    #(HALF/2) sda_pull_o = 1'b1;
    #(HALF/2) scl_o = 1'b1;
    #HALF sda_pull_o = 1'b0;
    #HALF;
  endtask
  // A missing acknowledge is only counted; the bench judges the total
  task automatic put_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    if (a) nacks++;
  endtask
  // ==========================================================================
  // Transactions: a word write keeps N and M in one operation
  task automatic write_regs(input logic [7:0] ofs, input logic [7:0] d[$]);
    start_cond();
    put_byte({CFR_SLV_ADDR, 1'b0});
    put_byte(ofs);
    foreach (d[i]) put_byte(d[i]);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] ofs);
    start_cond();
    put_byte({CFR_SLV_ADDR, 1'b0});
    put_byte(ofs);
    start_cond();
    put_byte({CFR_SLV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(rd_data[i]);
    put_bit(1'b1);  // Not acknowledged: read ends here
    stop_cond();
    -> rd_ev;
  endtask
endmodule
`default_nettype wire

// ===== cfr_freq_regs_tb.sv
// Self-checking bench for the CPU frequency program registers
`default_nettype none
module cfr_freq_regs_tb
  import cfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_i;
  logic       reset_i;
  logic       scl;
  logic       sda_pull;
  logic       sda_o;
  logic       sda_oe_n_o;
  logic [4:0] strap_pins;
  logic       override_flag;
  logic [4:0] soft_code;
  logic       wdt_timeout;
  logic       use_nm_o;
  logic [7:0] synth_n_o;
  logic [6:0] synth_m_o;
  logic [4:0] ratio_code_o;
  logic       retune;
  logic       rec_active;
  logic [4:0] strap_lat;
  logic [7:0] rn;
  logic [7:0] pn;
  logic [6:0] rm;
  logic [6:0] pm;
  cfr_freq_t  exp_q[$];
  logic [7:0] rd_q[$];
  int         num_errors = 0;
  int         samples_checked = 0;
  // Open-drain data wire with pull-up: low if either side pulls
  wire logic      sda_line = ~(sda_pull | (~sda_oe_n_o & ~sda_o));
  wire cfr_freq_t out_now  = {use_nm_o, synth_n_o, synth_m_o, ratio_code_o};

  cfr_freq_regs dut (
    .sys_clk_i             (sys_clk_i),
    .reset_i               (reset_i),
    .scl_i                 (scl),
    .sda_i                 (sda_line),
    .sda_o                 (sda_o),
    .sda_oe_n_o            (sda_oe_n_o),
    .strap_pins_i          (strap_pins),
    .strap_override_flag_i (override_flag),
    .soft_select_code_i    (soft_code),
    .wdt_timeout_i         (wdt_timeout),
    .use_nm_o              (use_nm_o),
    .synth_n_o             (synth_n_o),
    .synth_m_o             (synth_m_o),
    .ratio_code_o          (ratio_code_o),
    .retune_o              (retune),
    .recovery_active_o     (rec_active)
  );
  cfr_smb_host host (
    .scl_o      (scl),
    .sda_pull_o (sda_pull),
    .sda_i      (sda_line)
  );
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================================
  // Compare and closing tasks
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  // Only the fields the synthesizer uses in that mode are judged
  task automatic cmp_freq(input cfr_freq_t e, input cfr_freq_t g);
    if (e.use_nm) cmp("n and m", {1'b1, e.n, e.m}, {g.use_nm, g.n, g.m});
    else cmp("ratio", 16'({1'b0, e.ratio}), 16'({g.use_nm, g.ratio}));
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Each retune pulse takes the oldest expected setting; a stray one fails
  always @(negedge sys_clk_i)
  begin
    if (retune === 1'b1)
    begin
      if (exp_q.size() == 0) cmp("stray retune", 16'h0000, 16'h0001);
      else cmp_freq(exp_q.pop_front(), out_now);
    end
  end
  always @(host.rd_ev) cmp("read data", 16'(rd_q.pop_front()), 16'(host.rd_data));
  // ==========================================================================
  // Stimulus helpers, all on the falling edge
  task automatic clocks(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    clocks(10);
    reset_i = 1'b0;
    clocks(10);
  endtask
  task automatic wdt_pulse();
    clocks(1);
    wdt_timeout = 1'b1;
    clocks(1);
    wdt_timeout = 1'b0;
    clocks(4);
  endtask
  // Dividers drawn from a moderate band, never zero
  function automatic logic [7:0] rnd_n();
    return 8'h10 + 8'($urandom % 200);
  endfunction
  function automatic logic [6:0] rnd_m();
    return 7'h08 + 7'($urandom % 100);
  endfunction
  // Hang guard, well past the expected run time
  initial
  begin
    #900us;
    num_errors++;
    report_and_stop();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(8));
    strap_lat     = 5'($urandom);
    strap_pins    = strap_lat;
    override_flag = 1'b0;
    soft_code     = ~strap_lat;
    wdt_timeout   = 1'b0;
    reset_i       = 1'b1;
    do_reset();
    cmp("reset outputs", 16'h0001, 16'({use_nm_o, retune, rec_active, sda_oe_n_o}));
    for (int a = 11; a <= 15; a++)
    begin
      rd_q.push_back(8'h00);
      host.read_reg(8'(a));
    end
    // Straps are latched once; later pin changes must not show
    clocks(1);
    strap_pins = ~strap_lat;
    clocks(8);
    cmp("strap ratio", 16'(strap_lat), 16'(ratio_code_o));
    override_flag = 1'b1;
    clocks(8);
    cmp("soft ratio", 16'(soft_code), 16'(ratio_code_o));
    pn = rnd_n();
    pm = rnd_m();
    host.write_regs(CFR_OFS_PROG_N, '{pn});
    exp_q.push_back('{1'b1, pn, pm, 5'h00});
    host.write_regs(CFR_OFS_PROG_N, '{pn, {1'b1, pm}});
    // N-only write while programmable mode runs must not retune
    pn = rnd_n();
    host.write_regs(CFR_OFS_PROG_N, '{pn});
    exp_q.push_back('{1'b0, 8'h00, 7'h00, soft_code});
    host.write_regs(CFR_OFS_PROG_M, '{8'h00});
    rd_q.push_back(pn);
    host.read_reg(CFR_OFS_PROG_N);
    rn = rnd_n();
    rm = rnd_m();
    host.write_regs(CFR_OFS_REC_N, '{rn, {1'b1, rm}});
    exp_q.push_back('{1'b1, rn, rm, 5'h00});
    wdt_pulse();
    cmp("recovery active", 16'h0001, 16'(rec_active));
    rn = rnd_n();
    exp_q.push_back('{1'b1, rn, rm, 5'h00});
    host.write_regs(CFR_OFS_REC_N, '{rn});
    rm = rnd_m();
    exp_q.push_back('{1'b1, rn, rm, 5'h00});
    host.write_regs(CFR_OFS_REC_M, '{{1'b1, rm}});
    host.write_regs(CFR_OFS_PROG_M, '{{1'b1, pm}});
    // Second reset mid-run: recovery from straps, then switch to N and M
    clocks(1);
    strap_lat  = 5'($urandom);
    strap_pins = strap_lat;
    soft_code  = ~strap_lat;
    do_reset();
    host.write_regs(CFR_OFS_REC_N, '{rn, 8'h00});
    exp_q.push_back('{1'b0, 8'h00, 7'h00, strap_lat});
    wdt_pulse();
    exp_q.push_back('{1'b1, rn, rm, 5'h00});
    host.write_regs(CFR_OFS_REC_M, '{{1'b1, rm}});
    clocks(20);
    cmp("pending retunes", 16'h0000, 16'(exp_q.size()));
    cmp("host nacks", 16'h0000, 16'(host.nacks));
    report_and_stop();
  end
endmodule
`default_nettype wire
